// ===== dcsp_params.svh
`ifndef DCSP_PARAMS_SVH
`define DCSP_PARAMS_SVH

// shift register geometry
`define DCSP_SR_W        17
`define DCSP_SR_TOP      16
`define DCSP_POS_STACK   0
`define DCSP_POS_POT1    1
`define DCSP_POS_POT0    9
`define DCSP_WIPER_W     8

// reset values
`define DCSP_SR_RST      17'h00000
`define DCSP_WIPER_RST   8'h00
`define DCSP_STACK_RST   1'h0

// data buffer between frame capture and wiper update
`define DCSP_FIFO_DEPTH  8
`define DCSP_FIFO_AW     3

// number of looped shifts that bring the ring back home
`define DCSP_RING_LEN    5'h11

`endif

// ===== dcsp_pkg.sv
`default_nettype none

package dcsp_pkg;

  // capture side of the reference domain
  typedef enum logic [0:0] {
    DCSP_IDLE = 1'b0,
    DCSP_PEND = 1'b1
  } dcsp_state_t;

  typedef logic [16:0] dcsp_word_t;
  typedef logic [7:0]  dcsp_wiper_t;

endpackage

`default_nettype wire

// ===== dcsp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcsp_params.svh"

module dcsp_fifo #(
  parameter int WIDTH = `DCSP_SR_W,
  parameter int DEPTH = `DCSP_FIFO_DEPTH,
  parameter int AW    = `DCSP_FIFO_AW
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  full_out
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  wire              empty;
  wire              push;
  wire              pop;

  // pointer compare with wrap bit
  assign empty         = (wr_ptr_ff == rd_ptr_ff);
  assign full_out      = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                         (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign in_ready_out  = ~full_out;
  assign out_valid_out = ~empty;
  assign push          = in_valid_in & ~full_out;
  assign pop           = out_ready_in & ~empty;
  assign out_data_out  = mem[rd_ptr_ff[AW-1:0]];

  // storage, no reset needed
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data_in;
    end
  end

  // pointers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

endmodule // dcsp_fifo

`default_nettype wire

// ===== dcsp_top.sv
// Behaviour
// - cascade output carries the register tail so it can feed the next device.
// - with select high, the cascade output shows the top register bit.
// - each rising serial clock with select high loads input at bottom, next bit moves to output.
// - seventeen looped shifts per device return the data to its original places.
// - with hold low, select falling loads the register contents into both wipers and stack bit.
// - with select high, data is sampled on each rising serial clock.
// - bit 0 stack bit, bits 1-8 pot-1 MSB first, bits 9-16 pot-0 MSB first.
// - cascade output is always driven, whatever the select level.
`timescale 1ns/10ps
`default_nettype none
`include "dcsp_params.svh"

module dcsp_top (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       sclk_in,
  input  wire logic       sel_in,
  input  wire logic       data_in,
  input  wire logic       hold_in,
  output logic            cascade_out,
  output logic      [7:0] wiper0_out,
  output logic      [7:0] wiper1_out,
  output logic            stack_sel_out,
  output logic            fifo_full_out,
  output logic            pending_out
);

  // ------------------------------------------------------------------
  // link domain: serial clock, select frames the transfer
  // ------------------------------------------------------------------

  dcsp_pkg::dcsp_word_t sreg_ff;
  dcsp_pkg::dcsp_word_t nxt_sreg;

  // shift left, new bit enters at the bottom, top bit is the tail
  assign nxt_sreg = sel_in ? {sreg_ff[`DCSP_SR_TOP-1:0], data_in}
                           : sreg_ff;

  // shift register, only moves on serial clock edges inside a frame
  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sreg_ff <= `DCSP_SR_RST;
    end else begin
      sreg_ff <= nxt_sreg;
    end
  end

  // tail bit straight from the register, never released
  assign cascade_out = sreg_ff[`DCSP_SR_TOP];

  // helper for the ring check: consecutive looped shifts
  logic [4:0] ring_run_ff;
  wire        looped_shift;
  assign looped_shift = sel_in & (data_in == sreg_ff[`DCSP_SR_TOP]);

  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ring_run_ff <= 5'h00;
    end else if (!looped_shift) begin
      ring_run_ff <= 5'h00;
    end else if (ring_run_ff != `DCSP_RING_LEN) begin
      ring_run_ff <= ring_run_ff + 5'h01;
    end
  end

  // input bit lands at the bottom on a framed edge
  a_shift_in_bottom: assert property (
    @(posedge sclk_in) disable iff (!rst_n_in)
    sel_in |=> (sreg_ff[0] == $past(data_in)))
    else $error("serial input not loaded at bit 0");

  // next bit takes the tail after a framed edge
  a_tail_advance: assert property (
    @(posedge sclk_in) disable iff (!rst_n_in)
    sel_in |=> (sreg_ff[`DCSP_SR_TOP] == $past(sreg_ff[`DCSP_SR_TOP-1])))
    else $error("tail did not advance to next bit");

  // outside a frame nothing moves
  a_idle_hold: assert property (
    @(posedge sclk_in) disable iff (!rst_n_in)
    !sel_in |=> $stable(sreg_ff))
    else $error("shift register moved with select low");

  // deselected cascade pin keeps showing the held top bit
  a_cascade_tap: assert property (
    @(posedge sclk_in) disable iff (!rst_n_in)
    !sel_in |=> (cascade_out == $past(sreg_ff[`DCSP_SR_TOP])))
    else $error("cascade output not the top register bit");

  // seventeen looped shifts restore the contents
  a_ring_return: assert property (
    @(posedge sclk_in) disable iff (!rst_n_in)
    (looped_shift && ring_run_ff == 5'h10) |=> (sreg_ff == $past(sreg_ff, 17)))
    else $error("ring did not return to original contents");

  // ------------------------------------------------------------------
  // reference domain: select synchroniser and frame end detection
  // ------------------------------------------------------------------

  logic sel_s1_ff;
  logic sel_s2_ff;
  logic sel_s3_ff;
  logic hold_s1_ff;
  logic hold_s2_ff;
  wire  frame_end;

  // two stage synchronisers, first stage read by second only
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_s1_ff  <= 1'b0;
      sel_s2_ff  <= 1'b0;
      sel_s3_ff  <= 1'b0;
      hold_s1_ff <= 1'b0;
      hold_s2_ff <= 1'b0;
    end else begin
      sel_s1_ff  <= sel_in;
      sel_s2_ff  <= sel_s1_ff;
      sel_s3_ff  <= sel_s2_ff;
      hold_s1_ff <= hold_in;
      hold_s2_ff <= hold_s1_ff;
    end
  end

  // falling select seen after synchronisation
  assign frame_end = sel_s3_ff & ~sel_s2_ff;

  // ------------------------------------------------------------------
  // capture: the register is quiet while select is low, so the word
  // is stable by the time the synchronised fall arrives
  // ------------------------------------------------------------------

  dcsp_pkg::dcsp_state_t state_ff;
  dcsp_pkg::dcsp_state_t nxt_state;
  dcsp_pkg::dcsp_word_t  snap_ff;
  dcsp_pkg::dcsp_word_t  nxt_snap;
  wire                   fifo_in_ready;
  wire                   fifo_in_valid;
  wire                   push_done;

  assign fifo_in_valid = (state_ff == dcsp_pkg::DCSP_PEND);
  assign push_done     = fifo_in_valid & fifo_in_ready;

  // a new frame end overrides an unsent word; newest contents win
  assign nxt_snap = frame_end ? sreg_ff : snap_ff;

  // next state: a fresh frame end always leaves a word pending
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dcsp_pkg::DCSP_IDLE: begin
        if (frame_end) begin
          nxt_state = dcsp_pkg::DCSP_PEND;
        end
      end
      dcsp_pkg::DCSP_PEND: begin
        if (frame_end) begin
          nxt_state = dcsp_pkg::DCSP_PEND;
        end else if (push_done) begin
          nxt_state = dcsp_pkg::DCSP_IDLE;
        end
      end
      default: begin
        nxt_state = dcsp_pkg::DCSP_IDLE;
      end
    endcase
  end

  // capture state and snapshot
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= dcsp_pkg::DCSP_IDLE;
      snap_ff  <= `DCSP_SR_RST;
    end else begin
      state_ff <= nxt_state;
      snap_ff  <= nxt_snap;
    end
  end

  // ------------------------------------------------------------------
  // buffer between capture and wiper update; hold stalls the drain
  // ------------------------------------------------------------------

  wire                  fifo_out_valid;
  wire                  fifo_full;
  wire                  drain_ready;
  dcsp_pkg::dcsp_word_t fifo_out_data;

  assign drain_ready = ~hold_s2_ff;

  dcsp_fifo #(
    .WIDTH (`DCSP_SR_W),
    .DEPTH (`DCSP_FIFO_DEPTH),
    .AW    (`DCSP_FIFO_AW)
  ) dcsp_fifo_inst (
    .clk_in        (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (snap_ff),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (drain_ready),
    .out_data_out  (fifo_out_data),
    .full_out      (fifo_full)
  );

  // ------------------------------------------------------------------
  // field decode: stack bit at 0, pot-1 then pot-0, each MSB first
  // ------------------------------------------------------------------

  wire dcsp_pkg::dcsp_wiper_t pot0_field;
  wire dcsp_pkg::dcsp_wiper_t pot1_field;
  wire                        stack_field;
  wire                        apply;

  genvar gi;
  generate
    for (gi = 0; gi < `DCSP_WIPER_W; gi++) begin : g_field
      assign pot1_field[`DCSP_WIPER_W-1-gi] = fifo_out_data[`DCSP_POS_POT1+gi];
      assign pot0_field[`DCSP_WIPER_W-1-gi] = fifo_out_data[`DCSP_POS_POT0+gi];
    end
  endgenerate

  assign stack_field = fifo_out_data[`DCSP_POS_STACK];
  assign apply       = fifo_out_valid & drain_ready;

  // wiper settings change only when a captured word is applied
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wiper0_out    <= `DCSP_WIPER_RST;
      wiper1_out    <= `DCSP_WIPER_RST;
      stack_sel_out <= `DCSP_STACK_RST;
    end else if (apply) begin
      wiper0_out    <= pot0_field;
      wiper1_out    <= pot1_field;
      stack_sel_out <= stack_field;
    end
  end

  // registered status copies
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fifo_full_out <= 1'b0;
      pending_out   <= 1'b0;
    end else begin
      fifo_full_out <= fifo_full;
      pending_out   <= fifo_in_valid | fifo_out_valid;
    end
  end

  // a frame end snapshots its word and marks it pending on the next edge
  a_end_captures: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    frame_end |=> (state_ff == dcsp_pkg::DCSP_PEND) && (snap_ff == $past(sreg_ff)))
    else $error("frame end did not capture the shift register");

  // applied word reaches all three settings
  a_apply_fields: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    apply |=> (wiper0_out == $past(pot0_field)) && (wiper1_out == $past(pot1_field))
              && (stack_sel_out == $past(stack_field)))
    else $error("wiper settings not loaded from captured word");

  // bit layout of both wiper fields: pot-1 MSB at bit 1, pot-0 LSB at bit 16
  a_field_layout: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    apply |=> (wiper1_out[7] == $past(fifo_out_data[1])) &&
              (wiper0_out[0] == $past(fifo_out_data[16])))
    else $error("wiper field order wrong");

  // settings stay put while hold is in force
  a_hold_freeze: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    hold_s2_ff |=> $stable(wiper0_out) && $stable(wiper1_out) && $stable(stack_sel_out))
    else $error("settings changed while drain held");

  // pending word with space in the buffer is sent within one cycle
  a_pend_pushes: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (fifo_in_valid && !fifo_full && !frame_end) |=> (state_ff == dcsp_pkg::DCSP_IDLE))
    else $error("pending word not pushed into free buffer");

  // stack bit and the far ends of both fields land in place
  a_stack_tap: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    apply |=> (stack_sel_out == $past(fifo_out_data[0])) &&
              (wiper0_out[7] == $past(fifo_out_data[9])) &&
              (wiper1_out[0] == $past(fifo_out_data[8])))
    else $error("stack bit or field ends misplaced");

  // settings move only when a word is applied
  a_wiper_quiet: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !apply |=> $stable(wiper0_out) && $stable(wiper1_out) && $stable(stack_sel_out))
    else $error("settings changed without an applied word");

  // waiting word untouched until the next frame end
  a_snap_quiet: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !frame_end |=> $stable(snap_ff))
    else $error("snapshot changed without a frame end");

endmodule // dcsp_top

`default_nettype wire

// ===== dcsp_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module dcsp_host_model (
  input  wire logic        ref_clk_in,
  input  wire logic        cascade_in,
  output logic             sclk_out,
  output logic             sel_out,
  output logic             data_out,
  output logic      [16:0] rd_word_out
);
  logic drv_ff;
  logic loop_ff;

  // on a looped read the model routes the cascade input straight back to the data line
  assign data_out = loop_ff ? cascade_in : drv_ff;

  // idle bus, serial clock parked low
  initial begin
    sclk_out = 1'b0;
    sel_out = 1'b0;
    drv_ff = 1'b0;
    loop_ff = 1'b0;
    rd_word_out = 17'h00000;
  end

  // one framed transfer, msb first; reads the tail before each edge
  task automatic frame(input logic [16:0] w, input logic loop, input int slow);
    @(posedge ref_clk_in);
    loop_ff <= loop;
    sel_out <= 1'b1;
    #23;
    for (int i = 16; i >= 0; i--) begin
      rd_word_out[i] = cascade_in;
      drv_ff <= w[i];
      #(7.5 + slow) sclk_out <= 1'b1;
      #7.5 sclk_out <= 1'b0;
    end
    repeat (3) @(posedge ref_clk_in);
    sel_out <= 1'b0;
    loop_ff <= 1'b0;
    drv_ff <= ~drv_ff;
    repeat (10) @(posedge ref_clk_in);
  endtask

  // stray clocks with the port deselected, line wandering
  task automatic stray(input int n);
    repeat (n) begin
      #7.5 sclk_out <= 1'b1;
      drv_ff <= ~drv_ff;
      #7.5 sclk_out <= 1'b0;
    end
  endtask
endmodule // dcsp_host_model

`default_nettype wire

// ===== test_daisy_chain_shift_port.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: %s", $time, m); end end

module test_daisy_chain_shift_port;
  logic        ref_clk_in;
  logic        rst_n_in;
  logic        hold_in;
  wire logic   sclk;
  wire logic   sel;
  wire logic   data;
  logic        cascade;
  logic [7:0]  wiper0;
  logic [7:0]  wiper1;
  logic        stack;
  logic        full;
  logic        pending;
  logic [16:0] rd_word;
  logic [16:0] cur;
  logic [16:0] shown;
  logic [16:0] w;
  int          errors;
  int          tests_run;
  int          seed;

  dcsp_top dcsp_top_inst (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .sclk_in       (sclk),
    .sel_in        (sel),
    .data_in       (data),
    .hold_in       (hold_in),
    .cascade_out   (cascade),
    .wiper0_out    (wiper0),
    .wiper1_out    (wiper1),
    .stack_sel_out (stack),
    .fifo_full_out (full),
    .pending_out   (pending)
  );

  dcsp_host_model dcsp_host_model_inst (
    .ref_clk_in  (ref_clk_in),
    .cascade_in  (cascade),
    .sclk_out    (sclk),
    .sel_out     (sel),
    .data_out    (data),
    .rd_word_out (rd_word)
  );

  // reference clock, 100 ns
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // wiper fields are stored msb at the lower index
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = v[7-i];
    return r;
  endfunction

  function automatic logic [16:0] rnd17();
    logic [31:0] r;
    r = $random(seed);
    return r[16:0];
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // bounded wait until the captured word is applied
  task automatic settle();
    int n;
    n = 0;
    while (pending !== 1'b0 && n < 50) begin
      @(posedge ref_clk_in);
      n++;
    end
    @(posedge ref_clk_in);
    `CHK(n < 50, 1'b1, "apply wait")
  endtask

  task automatic expect_word(input logic [16:0] x);
    `CHK(wiper0, rev8(x[16:9]), "wiper0")
    `CHK(wiper1, rev8(x[8:1]), "wiper1")
    `CHK(stack, x[0], "stack bit")
    `CHK(cascade, x[16], "tail idle")
  endtask

  // write one frame; the bits read back are the previous contents
  task automatic wr(input logic [16:0] x, input int slow);
    dcsp_host_model_inst.frame(x, 1'b0, slow);
    `CHK(rd_word, cur, "shift out")
    cur = x;
    settle();
    expect_word(cur);
  endtask

  // hang guard
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    seed = 32'hB9FC;
    errors = 0;
    tests_run = 0;
    rst_n_in = 1'b0;
    hold_in = 1'b0;
    cur = 17'h00000;
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    expect_word(cur);
    `CHK({full, pending}, 2'h0, "reset flags")
    $display("test reset done");
    wr(17'h1FFFF, 0);
    wr(17'h00001, 0);
    wr(17'h10000, 40);
    wr(17'h0AAAA, 0);
    for (int i = 0; i < 6; i++) wr(rnd17(), (i % 2) * 40);
    $display("test writes done");
    for (int i = 0; i < 2; i++) begin
      dcsp_host_model_inst.frame(17'h00000, 1'b1, i * 60);
      `CHK(rd_word, cur, "loop read")
      settle();
      expect_word(cur);
    end
    $display("test loop read done");
    dcsp_host_model_inst.stray(20);
    repeat (10) @(posedge ref_clk_in);
    expect_word(cur);
    `CHK(pending, 1'b0, "stray capture")
    $display("test deselected clocks done");
    hold_in <= 1'b1;
    shown = cur;
    for (int i = 0; i < 9; i++) begin
      w = rnd17();
      dcsp_host_model_inst.frame(w, 1'b0, 0);
      `CHK(rd_word, cur, "held shift")
      cur = w;
    end
    `CHK(full, 1'b1, "buffer full")
    `CHK(pending, 1'b1, "pending held")
    `CHK(wiper0, rev8(shown[16:9]), "held wiper")
    hold_in <= 1'b0;
    settle();
    expect_word(cur);
    `CHK(full, 1'b0, "drained")
    $display("test buffer stall done");
    tally_and_finish();
  end
endmodule // test_daisy_chain_shift_port

`default_nettype wire
